// ---- logic/sbsr_pkg.sv ----
package sbsr_pkg;

  // Status byte field positions.
  localparam int unsigned ERRQ_BIT = 2;
  localparam int unsigned QUES_BIT = 3;
  localparam int unsigned MESSAGE_AVAILABLE_BIT = 4;
  localparam int unsigned EVENT_SUMMARY_BIT     = 5;
  localparam int unsigned MASTER_SUMMARY_BIT    = 6;
  localparam int unsigned OPER_BIT = 7;

  // Reset values.
  localparam logic [7:0]  MASK_RESET      = 8'h00;
  localparam logic [7:0]  STATUS_RESET    = 8'h00;
  localparam logic [15:0] LOWER_EN_RESET  = 16'h0000;

  // Bits of the status byte that feed the request summary.
  localparam logic [7:0]  SUMMARY_BITS    = 8'hBC;

  // Lower register width.
  localparam int unsigned LOWER_W = 16;

  typedef enum logic [1:0] {
    SBSR_CMD_NONE,
    SBSR_CMD_MASK_WR,
    SBSR_CMD_MASK_RD,
    SBSR_CMD_STATUS_RD
  } sbsr_cmd_t;

endpackage

// ---- logic/sbsr_reduce.sv ----
module sbsr_reduce (
  // Event bits and their enables.
  input  wire logic [15:0] event_i,
  input  wire logic [15:0] enable_i,
  // Summary.
  output logic             sum_o
);

  assign sum_o = |(event_i & enable_i);

endmodule

// ---- logic/sbsr_top.sv ----
module sbsr_top (
  // Clock and reset.
  input  wire logic        CLK_I,
  input  wire logic        SRST_I,
  // Command port from the remote interface parser.
  input  wire logic [1:0]  CMD_I,
  input  wire logic [7:0]  CMD_DATA_I,
  input  wire logic        SERIAL_POLL_I,
  // Lower level registers.
  input  wire logic [15:0] QUES_EVENT_I,
  input  wire logic [15:0] QUES_ENABLE_I,
  input  wire logic [15:0] OPER_EVENT_I,
  input  wire logic [15:0] OPER_ENABLE_I,
  input  wire logic [7:0]  STANDARD_EVENT_REGISTER_I,
  input  wire logic [7:0]  STANDARD_EVENT_ENABLE_I,
  // Error queue and output buffer.
  input  wire logic        ERRQ_NOT_EMPTY_I,
  input  wire logic        ERRQ_PUSH_I,
  input  wire logic        OUTBUF_NOT_EMPTY_I,
  // Answers and service request.
  output logic [7:0]       RESP_DATA_O,
  output logic             RESP_VALID_O,
  output logic [7:0]       STATUS_SUMMARY_BYTE_O,
  output logic [7:0]       REQUEST_ENABLE_MASK_O,
  output logic             SERVICE_REQUEST_O,
  output logic             SRQ_PULSE_O
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] status;
    logic [7:0] resp;
    logic       resp_valid;
    logic       srq;
    logic       srq_pulse;
  } sbsr_state_t;

  sbsr_state_t state_q;
  sbsr_state_t state_d;

  logic ques_sum;
  logic oper_sum;
  logic std_event_sum;

  sbsr_reduce u_ques (
    .event_i  (QUES_EVENT_I),
    .enable_i (QUES_ENABLE_I),
    .sum_o    (ques_sum)
  );

  sbsr_reduce u_oper (
    .event_i  (OPER_EVENT_I),
    .enable_i (OPER_ENABLE_I),
    .sum_o    (oper_sum)
  );

  // The standard event register is 8 bits; the upper half is padded with zero.
  sbsr_reduce u_std_event (
    .event_i  ({8'h00, STANDARD_EVENT_REGISTER_I}),
    .enable_i ({8'h00, STANDARD_EVENT_ENABLE_I}),
    .sum_o    (std_event_sum)
  );

  ////////////////////////////////////////////////////////////////////////////

  logic [7:0] base;
  logic [7:0] armed;
  logic [7:0] rising;
  logic       master_summary;
  logic       err_entry;

  always_comb begin
    base = sbsr_pkg::STATUS_RESET;
    base[sbsr_pkg::ERRQ_BIT] = ERRQ_NOT_EMPTY_I | ERRQ_PUSH_I;
    base[sbsr_pkg::QUES_BIT] = ques_sum;
    base[sbsr_pkg::MESSAGE_AVAILABLE_BIT] = OUTBUF_NOT_EMPTY_I;
    base[sbsr_pkg::EVENT_SUMMARY_BIT]     = std_event_sum;
    base[sbsr_pkg::OPER_BIT] = oper_sum;
    armed = base & state_q.mask & sbsr_pkg::SUMMARY_BITS;
    master_summary = |armed;
    rising = armed & ~(state_q.status & state_q.mask);
    // A push while the queue is already non-empty gives no edge, so it is
    // treated as its own request event when the error bit is enabled.
    err_entry = ERRQ_PUSH_I & state_q.mask[sbsr_pkg::ERRQ_BIT];
  end

  always_comb begin
    state_d = state_q;
    state_d.status = base;
    state_d.status[sbsr_pkg::MASTER_SUMMARY_BIT] = master_summary;
    state_d.srq = master_summary;
    state_d.srq_pulse = (|rising) | err_entry;
    state_d.resp_valid = 1'b0;
    if (CMD_I == sbsr_pkg::SBSR_CMD_MASK_WR) begin
      state_d.mask = CMD_DATA_I;
    end
    // Reads only copy; nothing in the status path is cleared by them.
    if (CMD_I == sbsr_pkg::SBSR_CMD_MASK_RD) begin
      state_d.resp = state_q.mask;
      state_d.resp_valid = 1'b1;
    end else if (CMD_I == sbsr_pkg::SBSR_CMD_STATUS_RD || SERIAL_POLL_I) begin
      state_d.resp = state_q.status;
      state_d.resp_valid = 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      state_q <= '0;
      state_q.mask <= sbsr_pkg::MASK_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign RESP_DATA_O           = state_q.resp;
  assign RESP_VALID_O          = state_q.resp_valid;
  assign STATUS_SUMMARY_BYTE_O = state_q.status;
  assign REQUEST_ENABLE_MASK_O = state_q.mask;
  assign SERVICE_REQUEST_O     = state_q.srq;
  assign SRQ_PULSE_O           = state_q.srq_pulse;

endmodule

// ---- tb/sbsr_ctrl_model.sv ----
module sbsr_ctrl_model (
  input  wire logic       clk_i, rv_i,
  input  wire logic [7:0] rd_i,
  output logic      [1:0] cmd_o,
  output logic      [7:0] data_o,
  output logic            poll_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {cmd_o, data_o, poll_o} = 11'h000;
  // One request per call, so each answer is read before the next request.
  task automatic req(input logic [1:0] c, input logic [7:0] d, input logic p,
    output logic [7:0] r);
    @(posedge clk_i) #1 {cmd_o, data_o, poll_o} = {c, d, p};
    @(posedge clk_i) #1 {cmd_o, data_o, poll_o} = {2'h0, ~d, 1'b0};
    r = rv_i ? rd_i : 8'hxx;
  endtask
endmodule

// ---- tb/sbsr_checker.sv ----
module sbsr_checker (
  input wire logic CLK_I, SRST_I, SERIAL_POLL_I, ERRQ_PUSH_I, OUTBUF_NOT_EMPTY_I, SRQ_PULSE_O,
  input wire logic RESP_VALID_O, SERVICE_REQUEST_O,
  input wire logic [1:0] CMD_I,
  input wire logic [7:0] CMD_DATA_I, RESP_DATA_O, STATUS_SUMMARY_BYTE_O, REQUEST_ENABLE_MASK_O
);
  wire logic [7:0] sb = STATUS_SUMMARY_BYTE_O;
  wire logic [7:0] mk = REQUEST_ENABLE_MASK_O;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  property p_low; sb[1:0] == 2'h0; endproperty
  a_low: assert property (p_low) else $error("low bits");
  property p_message; !$past(SRST_I) |-> sb[4] == $past(OUTBUF_NOT_EMPTY_I); endproperty
  a_message: assert property (p_message) else $error("message bit");
  // Only judged while mask and byte settle, since a fresh mask may lag one cycle.
  property p_srq; $stable({mk, sb}) |-> SERVICE_REQUEST_O == |(sb & mk & 8'hBC); endproperty
  a_srq: assert property (p_srq) else $error("request level");
  property p_ans; !$past(SRST_I) |-> RESP_VALID_O == $past(CMD_I[1] | SERIAL_POLL_I); endproperty
  a_ans: assert property (p_ans) else $error("answer strobe");
  property p_mrd; CMD_I == 2'h2 |=> RESP_DATA_O == mk; endproperty
  a_mrd: assert property (p_mrd) else $error("mask read");
  property p_srd; CMD_I == 2'h3 |=> RESP_DATA_O == $past(sb); endproperty
  a_srd: assert property (p_srd) else $error("status read");
  property p_wr; CMD_I == 2'h1 |=> mk == $past(CMD_DATA_I); endproperty
  a_wr: assert property (p_wr) else $error("mask write");
  property p_err; ERRQ_PUSH_I && mk[2] |=> SRQ_PULSE_O; endproperty
  a_err: assert property (p_err) else $error("error request");
endmodule
bind sbsr_top sbsr_checker sbsr_checker_inst (.*);

// ---- tb/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_I = 0, SRST_I = 1, SERIAL_POLL_I, ERRQ_NOT_EMPTY_I, ERRQ_PUSH_I = 0, r0;
  logic OUTBUF_NOT_EMPTY_I, RESP_VALID_O, SERVICE_REQUEST_O, SRQ_PULSE_O;
  logic [1:0] CMD_I;
  logic [7:0] CMD_DATA_I, RESP_DATA_O, STATUS_SUMMARY_BYTE_O, REQUEST_ENABLE_MASK_O, r;
  logic [7:0] STANDARD_EVENT_REGISTER_I = 8'h80, STANDARD_EVENT_ENABLE_I = 8'h01;
  logic [15:0] QUES_EVENT_I = 16'h0400, OPER_EVENT_I = 16'h0400;
  logic [15:0] QUES_ENABLE_I = 16'h0201, OPER_ENABLE_I = 16'h0201;
  int mismatches = 0, tests_run = 0;
  logic [31:0] rows [6] = '{32'h0080_0800, 32'h8040_C000, 32'h2020_6000, 32'h0410_4400,
    32'h4008_1000, 32'hFFF8_FC00};
  sbsr_top sbsr_top_inst (.*);
  sbsr_ctrl_model sbsr_ctrl_model_inst (.clk_i(CLK_I), .rv_i(RESP_VALID_O), .rd_i(RESP_DATA_O),
    .cmd_o(CMD_I), .data_o(CMD_DATA_I), .poll_o(SERIAL_POLL_I));
  initial forever #5 CLK_I = ~CLK_I;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d bad %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge CLK_I);
    #1 SRST_I = 0;
    foreach (rows[i]) begin
      sbsr_ctrl_model_inst.req(2'h1, rows[i][31:24], 1'b0, r);
      {QUES_EVENT_I[9], OPER_EVENT_I[9], STANDARD_EVENT_REGISTER_I[0], ERRQ_NOT_EMPTY_I,
        OUTBUF_NOT_EMPTY_I} = rows[i][23:19];
      @(posedge CLK_I) #1 check(STATUS_SUMMARY_BYTE_O, rows[i][15:8]);
      check({7'h00, SRQ_PULSE_O}, {7'h00, rows[i][14]});
      check({7'h00, SERVICE_REQUEST_O}, {7'h00, rows[i][14]});
      sbsr_ctrl_model_inst.req(i[0] ? 2'h0 : 2'h3, 8'h00, i[0], r);
      check(r, rows[i][15:8]);
      sbsr_ctrl_model_inst.req(2'h2, 8'h00, 1'b0, r);
      check(r, rows[i][31:24]);
    end
    sbsr_ctrl_model_inst.req(2'h1, 8'h04, 1'b0, r);
    repeat (2) begin
      @(posedge CLK_I) #1 ERRQ_PUSH_I = 1;
      @(posedge CLK_I) #1 ERRQ_PUSH_I = 0;
      check({7'h00, SRQ_PULSE_O}, 8'h01);
    end
    @(posedge CLK_I) #1 SRST_I = 1;
    @(posedge CLK_I) #1 SRST_I = 0;
    check(REQUEST_ENABLE_MASK_O, 8'h00);
    check(STATUS_SUMMARY_BYTE_O, 8'h00);
    check({7'h00, SERVICE_REQUEST_O}, 8'h00);
    @(posedge CLK_I) #1 check(STATUS_SUMMARY_BYTE_O, 8'hBC);
    give_verdict();
  end
endmodule
